// File: design/pmt_top.sv
// phy side mii transmit path, symbol mode remapping and receive clock generation
`default_nettype none
module pmt_top #(
    // substitute error code: arbitrary neutral value, set per product
    parameter logic [pmt_pkg::SYM_W-1:0] ALT_ERR_CODE = 5'h00
) (
    input  wire logic                       core_clk,
    input  wire logic                       reset,
    input  wire logic                       line_clk,
    input  wire logic                       cfg_speed_100,
    input  wire logic                       cfg_symbol_mode,
    input  wire logic                       cfg_alt_err_code,
    input  wire logic [pmt_pkg::NIB_W-1:0]  mii_txd,
    input  wire logic                       mii_tx_en,
    input  wire logic                       mii_tx_er,
    output logic                            mii_tx_clk,
    output logic [pmt_pkg::SYM_W-1:0]       line_tx_sym,
    output logic                            line_tx_active,
    input  wire logic                       line_rx_active,
    input  wire logic                       line_rx_edge,
    input  wire logic                       line_rx_frame,
    input  wire logic [pmt_pkg::SYM_W-1:0]  line_rx_sym,
    input  wire logic                       line_link_valid,
    input  wire logic                       line_collision,
    input  wire logic                       ref_in,
    output logic                            symbol_receive_clock,
    output logic [pmt_pkg::SYM_W-1:0]       symbol_receive_bits,
    output logic                            symbol_carrier_sense,
    output logic                            mii_col,
    output logic                            mii_rx_dv,
    input  wire logic                       mdc_pin,
    input  wire logic                       mdio_i,
    output logic                            mdio_o,
    output logic                            mdio_oe,
    output logic                            mgmt_mdc,
    output logic                            mgmt_mdio_i,
    input  wire logic                       mgmt_mdio_o,
    input  wire logic                       mgmt_mdio_oe
);
    import pmt_pkg::*;

    // ------------------------------------------------------------------
    // core domain: mode straps and management pins
    // ------------------------------------------------------------------
    logic [MODE_W-1:0] cfg_pins;
    logic [MODE_W-1:0] core_mode;
    logic [1:0]        mgmt_in;
    logic              mdio_o_r;
    logic              mdio_oe_r;

    assign cfg_pins[MODE_SPEED] = cfg_speed_100;
    assign cfg_pins[MODE_SYM]   = cfg_symbol_mode;
    assign cfg_pins[MODE_ALT]   = cfg_alt_err_code;

    // pins are asynchronous to the core, so filter them
    pmt_sync #(.W(MODE_W), .FILTER(1'b1)) u_cfg_sync (
        .clk (core_clk),
        .rst (reset),
        .d   (cfg_pins),
        .q   (core_mode)
    );

    // management clock and data in, same path in every mode
    pmt_sync #(.W(2), .FILTER(1'b1)) u_mgmt_sync (
        .clk (core_clk),
        .rst (reset),
        .d   ({mdio_i, mdc_pin}),
        .q   (mgmt_in)
    );

    assign mgmt_mdc    = mgmt_in[0];
    assign mgmt_mdio_i = mgmt_in[1];

    // data out and enable registered, never gated by symbol mode
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mdio_o_r  <= 1'b0;
            mdio_oe_r <= 1'b0;
        end else begin
            mdio_o_r  <= mgmt_mdio_o;
            mdio_oe_r <= mgmt_mdio_oe;
        end
    end

    assign mdio_o  = mdio_o_r;
    assign mdio_oe = mdio_oe_r;

    // ------------------------------------------------------------------
    // link domain: reset release and crossings
    // ------------------------------------------------------------------
    logic              line_rst_s1;
    logic              line_rst;
    logic [MODE_W-1:0] line_mode;
    logic              ref_lvl;
    logic              ref_prev_r;
    logic              ref_tick;
    logic              speed100;
    logic              sym_mode;
    logic              alt_mode;

    // assert at once, release on the link clock
    always_ff @(posedge line_clk or posedge reset) begin
        if (reset) begin
            line_rst_s1 <= 1'b1;
            line_rst    <= 1'b1;
        end else begin
            line_rst_s1 <= 1'b0;
            line_rst    <= line_rst_s1;
        end
    end

    // mode comes from core flops, a level, so two stages suffice
    pmt_sync #(.W(MODE_W), .FILTER(1'b0)) u_mode_cross (
        .clk (line_clk),
        .rst (line_rst),
        .d   (core_mode),
        .q   (line_mode)
    );

    pmt_sync #(.W(1), .FILTER(1'b1)) u_ref_sync (
        .clk (line_clk),
        .rst (line_rst),
        .d   (ref_in),
        .q   (ref_lvl)
    );

    always_ff @(posedge line_clk or posedge line_rst) begin
        if (line_rst) begin
            ref_prev_r <= 1'b0;
        end else begin
            ref_prev_r <= ref_lvl;
        end
    end

    assign ref_tick = ref_lvl & ~ref_prev_r;
    assign speed100 = line_mode[MODE_SPEED];
    assign sym_mode = line_mode[MODE_SYM];
    assign alt_mode = line_mode[MODE_ALT];

    // ------------------------------------------------------------------
    // transmit clock and transmit path
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] half_cnt;
    logic [CNT_W-1:0] tx_cnt_r;
    logic             tx_clk_r;
    logic             tx_wrap;
    logic             tx_rise;
    logic [SYM_W-1:0] tx_sym_nxt;
    logic             tx_act_nxt;
    logic [SYM_W-1:0] tx_sym_r;
    logic             tx_act_r;

    assign half_cnt = speed100 ? HALF_100 : HALF_10;
    assign tx_wrap  = (tx_cnt_r >= half_cnt - CNT_ONE);
    assign tx_rise  = tx_wrap & ~tx_clk_r;

    // >= lets a speed change shorten the count without a stall
    always_ff @(posedge line_clk or posedge line_rst) begin
        if (line_rst) begin
            tx_cnt_r <= CNT_RST;
            tx_clk_r <= 1'b0;
        end else if (tx_wrap) begin
            tx_cnt_r <= CNT_RST;
            tx_clk_r <= ~tx_clk_r;
        end else begin
            tx_cnt_r <= tx_cnt_r + CNT_ONE;
        end
    end

    // next line symbol, taken at the edge where the clock pin rises
    always_comb begin
        tx_sym_nxt = SYM_RST;
        tx_act_nxt = 1'b0;
        if (sym_mode) begin
            tx_sym_nxt = {mii_tx_er, mii_txd};
            tx_act_nxt = 1'b1;
        end else if (mii_tx_en) begin
            tx_act_nxt = 1'b1;
            if (speed100 && mii_tx_er) begin
                tx_sym_nxt = alt_mode ? ALT_ERR_CODE : HALT_SYM;
            end else if (speed100) begin
                tx_sym_nxt = pmt_enc_4b5b(mii_txd);
            end else begin
                tx_sym_nxt = {1'b0, mii_txd};
            end
        end else begin
            tx_sym_nxt = speed100 ? IDLE_SYM : SYM_RST;
        end
    end

    always_ff @(posedge line_clk or posedge line_rst) begin
        if (line_rst) begin
            tx_sym_r <= SYM_RST;
            tx_act_r <= 1'b0;
        end else if (tx_rise) begin
            tx_sym_r <= tx_sym_nxt;
            tx_act_r <= tx_act_nxt;
        end
    end

    assign mii_tx_clk     = tx_clk_r;
    assign line_tx_sym    = tx_sym_r;
    assign line_tx_active = tx_act_r;

    // ------------------------------------------------------------------
    // receive clock: recovered phase counter with realignment
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] rx_cnt_r;
    logic             symbol_receive_clock_r;
    logic             rx_wrap;
    logic             pkt_aligned_r;
    logic             link_aligned_r;
    logic             align_pkt;
    logic             align_link;
    logic             align_ref;
    logic             align_now;
    logic             symbol_receive_clock_rise;

    assign align_pkt  = ~speed100 & line_rx_active & ~pkt_aligned_r & line_rx_edge;
    assign align_link = speed100 & line_link_valid & ~link_aligned_r & line_rx_edge;
    assign align_ref  = speed100 & ~line_link_valid & ref_tick;
    assign align_now  = align_pkt | align_link | align_ref;
    assign rx_wrap    = (rx_cnt_r >= half_cnt - CNT_ONE);
    assign symbol_receive_clock_rise = rx_wrap & ~symbol_receive_clock_r & ~align_now;

    // realign restarts the low phase; the receiver absorbs that jump
    always_ff @(posedge line_clk or posedge line_rst) begin
        if (line_rst) begin
            rx_cnt_r <= CNT_RST;
            symbol_receive_clock_r  <= 1'b0;
        end else if (align_now) begin
            rx_cnt_r <= CNT_RST;
            symbol_receive_clock_r  <= 1'b0;
        end else if (rx_wrap) begin
            rx_cnt_r <= CNT_RST;
            symbol_receive_clock_r  <= ~symbol_receive_clock_r;
        end else begin
            rx_cnt_r <= rx_cnt_r + CNT_ONE;
        end
    end

    // one realign per packet at 10, one per link at 100
    always_ff @(posedge line_clk or posedge line_rst) begin
        if (line_rst) begin
            pkt_aligned_r  <= 1'b0;
            link_aligned_r <= 1'b0;
        end else begin
            if (align_pkt) begin
                pkt_aligned_r <= 1'b1;
            end else if (!line_rx_active) begin
                pkt_aligned_r <= 1'b0;
            end
            if (align_link) begin
                link_aligned_r <= 1'b1;
            end else if (!line_link_valid) begin
                link_aligned_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // receive side status outputs
    // ------------------------------------------------------------------
    logic             crs_r;
    logic             col_r;
    logic             rx_dv_r;
    logic [SYM_W-1:0] srd_r;

    // data valid only once the clock has changed over to line timing
    always_ff @(posedge line_clk or posedge line_rst) begin
        if (line_rst) begin
            crs_r   <= 1'b0;
            col_r   <= 1'b0;
            rx_dv_r <= 1'b0;
        end else begin
            crs_r   <= line_rx_active;
            col_r   <= ~sym_mode & line_collision;
            rx_dv_r <= ~sym_mode & line_rx_frame &
                       (speed100 ? link_aligned_r : pkt_aligned_r);
        end
    end

    // symbols pass unframed on each receive clock rise
    always_ff @(posedge line_clk or posedge line_rst) begin
        if (line_rst) begin
            srd_r <= SYM_RST;
        end else if (symbol_receive_clock_rise) begin
            srd_r <= line_rx_sym;
        end
    end

    assign symbol_receive_clock = symbol_receive_clock_r;
    assign symbol_receive_bits  = srd_r;
    assign symbol_carrier_sense = crs_r;
    assign mii_col              = col_r;
    assign mii_rx_dv            = rx_dv_r;

    // ------------------------------------------------------------------
    // checks on the link domain
    // ------------------------------------------------------------------
    a_tx_halt_sub: assert property (@(posedge line_clk) disable iff (line_rst)
        (tx_rise && !sym_mode && speed100 && mii_tx_en && mii_tx_er && !alt_mode) |=> (tx_sym_r == HALT_SYM))
        else $error("halt code not substituted on transmit error");
    a_tx_alt_code: assert property (@(posedge line_clk) disable iff (line_rst)
        (tx_rise && !sym_mode && speed100 && mii_tx_en && mii_tx_er && alt_mode) |=> (tx_sym_r == ALT_ERR_CODE))
        else $error("alternate error code not sent");
    a_tx_stop_line: assert property (@(posedge line_clk) disable iff (line_rst)
        (tx_rise && !sym_mode && !mii_tx_en) |=>
        ((!tx_act_r [*2]) and (tx_sym_r == ($past(speed100) ? IDLE_SYM : SYM_RST))))
        else $error("transmission continued after enable dropped");
    a_tx_ten_ignore: assert property (@(posedge line_clk) disable iff (line_rst)
        (tx_rise && !sym_mode && !speed100 && mii_tx_en) |=> (tx_sym_r == {1'b0, $past(mii_txd)} && tx_act_r))
        else $error("10m nibble altered or error honoured");
    a_tx_hundred_enc: assert property (@(posedge line_clk) disable iff (line_rst)
        (tx_rise && !sym_mode && speed100 && mii_tx_en && !mii_tx_er) |=>
        (tx_sym_r == pmt_enc_4b5b($past(mii_txd))))
        else $error("100m nibble not encoded");
    a_sym_sample: assert property (@(posedge line_clk) disable iff (line_rst)
        (tx_rise && sym_mode) |=> (tx_sym_r == {$past(mii_tx_er), $past(mii_txd)} && tx_act_r))
        else $error("symbol bits not sampled in symbol mode");
    a_col_quiet: assert property (@(posedge line_clk) disable iff (line_rst)
        (sym_mode && $past(sym_mode)) |-> !col_r)
        else $error("collision driven in symbol mode");
    a_crs_follow: assert property (@(posedge line_clk) disable iff (line_rst)
        ##1 (crs_r == $past(line_rx_active)))
        else $error("carrier sense does not follow line activity");
    a_dv_after_lock: assert property (@(posedge line_clk) disable iff (line_rst)
        $rose(rx_dv_r) |-> ($past(pkt_aligned_r || link_aligned_r) && !$past(sym_mode)))
        else $error("data valid before clock changeover or in symbol mode");
    a_link_no_realign: assert property (@(posedge line_clk) disable iff (line_rst)
        (speed100 && line_link_valid && link_aligned_r && !rx_wrap) |=> (rx_cnt_r == $past(rx_cnt_r) + CNT_ONE))
        else $error("100m receive clock realigned within a link");
    a_ten_free_run: assert property (@(posedge line_clk) disable iff (line_rst)
        (!speed100 && !line_rx_active && !rx_wrap) |=> (rx_cnt_r == $past(rx_cnt_r) + CNT_ONE))
        else $error("10m receive clock stopped after data ended");
    a_ref_follow: assert property (@(posedge line_clk) disable iff (line_rst)
        (speed100 && !line_link_valid && ref_tick) |=> (rx_cnt_r == CNT_RST && !symbol_receive_clock_r))
        else $error("receive clock not aligned to reference without link");
endmodule
`default_nettype wire

// File: design/pmt_pkg.sv
// constants, encodings and timing counts for the phy mii transmit and symbol clock block
`default_nettype none
package pmt_pkg;
    // ------------------------------------------------------------------
    // widths and mode bits
    // ------------------------------------------------------------------
    localparam int             NIB_W      = 4;
    localparam int             SYM_W      = 5;
    localparam int             MODE_W     = 3;
    localparam int             MODE_SPEED = 0;
    localparam int             MODE_SYM   = 1;
    localparam int             MODE_ALT   = 2;
    localparam logic [2:0]     MODE_RST   = 3'h0;

    // ------------------------------------------------------------------
    // code groups
    // ------------------------------------------------------------------
    localparam logic [4:0]     HALT_SYM   = 5'h04;
    localparam logic [4:0]     IDLE_SYM   = 5'h1f;
    localparam logic [4:0]     SYM_RST    = 5'h00;

    // ------------------------------------------------------------------
    // timing: link clock rate and the two line rates
    // ------------------------------------------------------------------
    localparam int             LINE_CLK_HZ = 100_000_000;
    localparam int             CLK_100_HZ  = 25_000_000;
    localparam int             CLK_10_HZ   = 2_500_000;
    localparam int             CNT_W       = 8;
    localparam logic [7:0]     CNT_ONE     = 8'h01;
    localparam logic [7:0]     CNT_RST     = 8'h00;
    // half periods round down (shortest time), never below one cycle
    localparam int             HALF_100_I  = LINE_CLK_HZ / (2 * CLK_100_HZ);
    localparam int             HALF_10_I   = LINE_CLK_HZ / (2 * CLK_10_HZ);
    localparam logic [7:0]     HALF_100    = CNT_W'((HALF_100_I < 1) ? 1 : HALF_100_I);
    localparam logic [7:0]     HALF_10     = CNT_W'((HALF_10_I < 1) ? 1 : HALF_10_I);

    // standard 4b/5b data encoding, nibble bit 0 is the lsb
    function automatic logic [4:0] pmt_enc_4b5b(input logic [3:0] nib);
        logic [4:0] s;
        s = 5'h00;
        case (nib)
            4'h0:    s = 5'h1e;
            4'h1:    s = 5'h09;
            4'h2:    s = 5'h14;
            4'h3:    s = 5'h15;
            4'h4:    s = 5'h0a;
            4'h5:    s = 5'h0b;
            4'h6:    s = 5'h0e;
            4'h7:    s = 5'h0f;
            4'h8:    s = 5'h12;
            4'h9:    s = 5'h13;
            4'ha:    s = 5'h16;
            4'hb:    s = 5'h17;
            4'hc:    s = 5'h1a;
            4'hd:    s = 5'h1b;
            4'he:    s = 5'h1c;
            default: s = 5'h1d;
        endcase
        return s;
    endfunction
endpackage
`default_nettype wire

// File: design/pmt_sync.sv
// input synchroniser: three-stage agreement filter or plain two-stage crossing
`default_nettype none
module pmt_sync #(
    parameter int       W      = 1,
    parameter bit       FILTER = 1'b1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;

    // first stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end

    generate
        if (FILTER) begin : g_filt
            logic [W-1:0] s3_r;
            logic [W-1:0] q_r;
            // a change counts once stages two and three agree
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    s3_r <= '0;
                    q_r  <= '0;
                end else begin
                    s3_r <= s2_r;
                    for (int i = 0; i < W; i++) begin
                        if (s2_r[i] == s3_r[i]) begin
                            q_r[i] <= s3_r[i];
                        end
                    end
                end
            end
            assign q = q_r;
        end else begin : g_plain
            assign q = s2_r;
        end
    endgenerate
endmodule
`default_nettype wire

// File: bench/pmt_mac_model.sv
// mac side model: presents one transmit nibble per transmit clock period
`default_nettype none
module pmt_mac_model (
    input  wire logic                      mii_tx_clk,
    input  wire logic                      run,
    output logic [pmt_pkg::NIB_W-1:0]      mii_txd,
    output logic                           mii_tx_en,
    output logic                           mii_tx_er
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------------
    // transmit side
    // ------------------------------------------------------------------
    initial begin
        mii_txd   = 4'h0;
        mii_tx_en = 1'b0;
        mii_tx_er = 1'b0;
    end

    // new values just after each rise, then held for the whole period
    always @(posedge mii_tx_clk) begin
        #1;
        mii_txd   <= 4'($urandom);
        mii_tx_en <= run & ($urandom_range(3) != 0); // random gaps end frames
        mii_tx_er <= ($urandom_range(3) == 0); // errors also outside frames
    end
endmodule
`default_nettype wire

// File: bench/tb_phy_mii_tx_and_symbol_rx_clock.sv
// self-checking bench for the transmit path and symbol receive clock block
`default_nettype none
module tb_phy_mii_tx_and_symbol_rx_clock import pmt_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [4:0] ALT = 5'h1b;
    logic       core_clk = 0, line_clk = 0, reset = 1, ref_in = 0, run = 0, chk = 0;
    logic       cfg_speed_100 = 0, cfg_symbol_mode = 0, cfg_alt_err_code = 0;
    logic       line_rx_active = 0, line_rx_edge = 0, line_rx_frame = 0, line_link_valid = 0;
    logic       line_collision = 0, mdc_pin = 0, mdio_i = 0, mgmt_mdio_o = 0, mgmt_mdio_oe = 0;
    logic [3:0] mii_txd;
    logic [4:0] line_tx_sym, symbol_receive_bits, line_rx_sym = 5'h15;
    logic       mii_tx_en, mii_tx_er, mii_tx_clk, line_tx_active, symbol_receive_clock;
    logic       symbol_carrier_sense, mii_col, mii_rx_dv, mdio_o, mdio_oe, mgmt_mdc, mgmt_mdio_i;
    int         failures = 0, n_compared = 0, cyc = 0;
    logic [4:0] enc [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                             5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

    // ------------------------------------------------------------------
    // clocks and instances
    // ------------------------------------------------------------------
    always #50 core_clk = ~core_clk;
    always #40 line_clk = ~line_clk; // edges meet the core edges once every 200 ns
    always #160 ref_in = ~ref_in; // slow enough to be seen, rises land on link clock edges

    pmt_top #(.ALT_ERR_CODE(ALT)) dut (
        .core_clk, .reset, .line_clk, .cfg_speed_100, .cfg_symbol_mode, .cfg_alt_err_code,
        .mii_txd, .mii_tx_en, .mii_tx_er, .mii_tx_clk, .line_tx_sym, .line_tx_active,
        .line_rx_active, .line_rx_edge, .line_rx_frame, .line_rx_sym, .line_link_valid,
        .line_collision, .ref_in, .symbol_receive_clock, .symbol_receive_bits,
        .symbol_carrier_sense, .mii_col, .mii_rx_dv, .mdc_pin, .mdio_i, .mdio_o, .mdio_oe,
        .mgmt_mdc, .mgmt_mdio_i, .mgmt_mdio_o, .mgmt_mdio_oe
    );
    pmt_mac_model mac (.mii_tx_clk, .run, .mii_txd, .mii_tx_en, .mii_tx_er);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_compared++;
        if (seen !== want) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic stop_test();
        if (failures == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // {active, symbol} expected for what was sampled at a transmit clock rise
    function automatic logic [7:0] exp_tx(input logic e, input logic r, input logic [3:0] n);
        if (cfg_symbol_mode)
            return {3'h1, r, n};
        if (!cfg_speed_100)
            return {2'h0, e, 1'b0, e ? n : 4'h0};
        if (!e)
            return {3'h0, IDLE_SYM};
        if (r)
            return {3'h1, cfg_alt_err_code ? ALT : HALT_SYM};
        return {3'h1, enc[n]};
    endfunction

    // one half period of a clock, in link clock cycles
    task automatic half_is(input bit rx, input logic [7:0] want);
        realtime t;
        @(rx ? symbol_receive_clock : mii_tx_clk);
        t = $realtime;
        @(rx ? symbol_receive_clock : mii_tx_clk);
        check(8'(int'(($realtime - t) / 80.0)), want);
    endtask

    task automatic rx_pulse();
        @(posedge line_clk);
        #1 line_rx_edge = 1;
        @(posedge line_clk);
        #1 line_rx_edge = 0;
    endtask

    // snapshot what the design sampled at this rise, look once it has landed
    always @(posedge mii_tx_clk) begin
        logic [3:0] n;
        logic       e, r;
        n = mii_txd;
        e = mii_tx_en;
        r = mii_tx_er;
        #2;
        if (chk)
            check({2'h0, line_tx_active, line_tx_sym}, exp_tx(e, r, n));
    end

    // a hang is cut short well beyond the expected run length
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------
    // main sequence: 10M, 100M, 100M alternate code, symbol mode
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(60));
        repeat (5) @(posedge core_clk);
        #1 reset = 0;
        for (int m = 0; m < 4; m++) begin
            @(posedge core_clk);
            #1 chk = 0;
            cfg_speed_100 = (m > 0);
            cfg_alt_err_code = (m == 2);
            cfg_symbol_mode = (m == 3);
            line_collision = 1;
            line_rx_frame = 1;
            {mdc_pin, mdio_i, mgmt_mdio_o, mgmt_mdio_oe} = 4'($urandom);
            line_rx_sym = 5'($urandom);
            run = 1;
            repeat (20) @(posedge core_clk); // mode has crossed into the link domain
            chk = 1;
            half_is(0, cfg_speed_100 ? HALF_100 : HALF_10);
            repeat (40) @(posedge mii_tx_clk);
            chk = 0;
            check({6'h0, mdio_o, mdio_oe}, {6'h0, mgmt_mdio_o, mgmt_mdio_oe});
            check({6'h0, mgmt_mdc, mgmt_mdio_i}, {6'h0, mdc_pin, mdio_i});
            check({7'h0, mii_col}, {7'h0, !cfg_symbol_mode});
            if (cfg_symbol_mode)
                check({2'h0, mii_rx_dv, symbol_receive_bits}, {3'h0, line_rx_sym});
            check({6'h0, symbol_carrier_sense, mii_rx_dv}, 8'h00);
            @(posedge line_clk);
            #1 line_rx_active = 1;
            line_link_valid = 1;
            rx_pulse();
            repeat (30) @(posedge line_clk);
            check({7'h0, symbol_carrier_sense}, 8'h01);
            check({7'h0, mii_rx_dv}, {7'h0, !cfg_symbol_mode});
            rx_pulse(); // a second edge in the same packet must not realign
            half_is(1, cfg_speed_100 ? HALF_100 : HALF_10);
            @(posedge line_clk);
            #1 line_rx_active = 0;
            line_link_valid = 0;
        end
        stop_test();
    end
endmodule
`default_nettype wire
